// file: include/dacc_pkg.sv
// package of constants and types for the dsp accumulator datapath
package dacc_pkg;
   // accumulator field widths
   localparam int ACC_W = 40;
   localparam int GUARD_W = 8;
   localparam int WORD_W = 16;
   localparam int PROD_W = 32;
   // core control bit positions
   localparam int CTL_W = 16;
   localparam int CTL_IF_BIT = 0;
   localparam int CTL_SSAT_BIT = 4;
   localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;
   // register index map, one word each; the first accumulator occupies 0..2
   localparam int ADDR_W = 3;
   localparam logic [ADDR_W-1:0] REG_FIRST_LOW = 3'h0;
   localparam logic [ADDR_W-1:0] REG_FIRST_HIGH = 3'h1;
   localparam logic [ADDR_W-1:0] REG_FIRST_GUARD = 3'h2;
   localparam logic [ADDR_W-1:0] REG_SECOND_LOW = 3'h3;
   localparam logic [ADDR_W-1:0] REG_SECOND_HIGH = 3'h4;
   localparam logic [ADDR_W-1:0] REG_SECOND_GUARD = 3'h5;
   localparam logic [ADDR_W-1:0] REG_CORE_CTL = 3'h6;
   localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;
   // accumulator operations issued by the core
   typedef enum logic [2:0] {
      DACC_OP_NONE = 3'b000,
      DACC_OP_MPY = 3'b001,
      DACC_OP_MAC = 3'b010,
      DACC_OP_MSC = 3'b011,
      DACC_OP_LOAD = 3'b100,
      DACC_OP_STORE = 3'b101,
      DACC_OP_STORE_RND = 3'b110,
      DACC_OP_ADD = 3'b111
   } dacc_op_t;
endpackage

// file: core/dacc_mult.sv
// signed 16x16 multiplier with fractional alignment shift
`timescale 1ns/1ns
module dacc_mult
   import dacc_pkg::*;
(
   input wire logic [WORD_W-1:0] op_x, // x path operand
   input wire logic [WORD_W-1:0] op_y, // y path operand
   input wire logic int_mode, // 1 integer, 0 fractional
   output logic [PROD_W-1:0] product // aligned product
);
   wire logic signed [PROD_W-1:0] raw_prod;
   // two's complement operands, msb is sign
   assign raw_prod = $signed(op_x) * $signed(op_y); // RULE1 RULE2
   // fractional 2.30 moves up one place to 1.31; integer stays unshifted
   assign product = int_mode ? raw_prod : {raw_prod[PROD_W-2:0], 1'b0}; // RULE8 RULE9
endmodule // dacc_mult

// file: core/dacc_core.sv
// two 40-bit dsp accumulators with load, store, multiply and register access
// Function
// [RULE1] integer operands are signed two's complement
// [RULE2] fractional operands are 1.15 two's complement
// [RULE3] normal mode uses 32-bit 1.31 accumulators
// [RULE4] super saturation bit widens accumulators to 40
// [RULE5] fractions stay 1.31 aligned, guard extends range
// [RULE6] non-multiply arithmetic identical for both formats
// [RULE7] control bit 0: 0 fractional, 1 integer
// [RULE8] integer multiply gives unshifted 32-bit product
// [RULE9] fractional product shifted left by one
// [RULE10] accumulator is guard, high, low concatenated
// [RULE11] load: high gets word, low zero, guard sign
// [RULE12] store takes word from high register
// [RULE13] normal mode: guard is sign extension only
// [RULE14] super saturation: results use all 40 bits
// [RULE15] six accumulator registers memory mapped read/write
// [RULE16] guard reads back sign-extended to 16 bits
// [RULE17] software should prefer load/store instructions
// [RULE18] mode bits sampled per executed instruction
`timescale 1ns/1ns
module dacc_core
   import dacc_pkg::*;
(
   input wire logic mclk, // 25 mhz core clock
   input wire logic resetn, // synchronous reset, active low
   input wire logic op_valid, // dsp instruction executes this cycle
   input wire dacc_op_t op_code, // operation selector
   input wire logic op_acc_sel, // 0 first accumulator, 1 second
   input wire logic [WORD_W-1:0] op_x, // x data path word
   input wire logic [WORD_W-1:0] op_y, // y data path word
   output logic [WORD_W-1:0] store_data, // word produced by store
   output logic store_valid, // store_data updated pulse
   input wire logic reg_wr, // special-function write strobe
   input wire logic reg_rd, // special-function read strobe
   input wire logic reg_byte, // byte-wide access, low byte only
   input wire logic [ADDR_W-1:0] reg_addr, // register index
   input wire logic [WORD_W-1:0] reg_wdata, // write data
   output logic [WORD_W-1:0] reg_rdata, // read data
   output logic [CTL_W-1:0] core_control_reg // core control contents
);
   import dacc_pkg::*;

   logic [ACC_W-1:0] acc_reg [2];
   logic [ACC_W-1:0] acc_next [2];
   logic [CTL_W-1:0] ctl_reg;
   logic [CTL_W-1:0] ctl_next;
   logic [WORD_W-1:0] rdata_reg;
   logic [WORD_W-1:0] store_reg;
   logic store_vld_reg;

   // mode bits read straight from the live control word at execution
   wire logic int_mode = ctl_reg[CTL_IF_BIT]; // RULE7 RULE18
   wire logic super_sat = ctl_reg[CTL_SSAT_BIT]; // RULE4 RULE18
   wire logic [ACC_W-1:0] acc_sel = acc_reg[op_acc_sel];
   wire logic [PROD_W-1:0] product;

   dacc_mult u_mult (
      .op_x(op_x),
      .op_y(op_y),
      .int_mode(int_mode),
      .product(product)
   );

   // product sign extended to 40 bits; radix point stays at bit 31
   wire logic [ACC_W-1:0] prod_ext = {{GUARD_W{product[PROD_W-1]}}, product}; // RULE5
   // add and subtract are plain binary, format only changes meaning
   wire logic [ACC_W-1:0] sum_mac = acc_sel + prod_ext; // RULE6
   wire logic [ACC_W-1:0] sum_msc = acc_sel - prod_ext; // RULE6
   wire logic [ACC_W-1:0] sum_acc = acc_reg[0] + acc_reg[1]; // RULE6
   // raw arithmetic result before mode shaping
   wire logic [ACC_W-1:0] arith_res =
      (op_code == DACC_OP_MPY) ? prod_ext :
      (op_code == DACC_OP_MAC) ? sum_mac :
      (op_code == DACC_OP_MSC) ? sum_msc : sum_acc;
   // normal mode keeps only 32 bits and regenerates guard from bit 31
   wire logic [ACC_W-1:0] dsp_res = super_sat ? arith_res : // RULE14
      {{GUARD_W{arith_res[PROD_W-1]}}, arith_res[PROD_W-1:0]}; // RULE3 RULE13
   // load places word in high, zero low, sign into guard
   wire logic [ACC_W-1:0] load_val =
      {{GUARD_W{op_x[WORD_W-1]}}, op_x, {WORD_W{1'b0}}}; // RULE11
   wire logic is_arith = op_valid && (op_code == DACC_OP_MPY || op_code == DACC_OP_MAC ||
                                      op_code == DACC_OP_MSC || op_code == DACC_OP_ADD);
   wire logic is_load = op_valid && op_code == DACC_OP_LOAD;
   wire logic is_store = op_valid && (op_code == DACC_OP_STORE ||
                                      op_code == DACC_OP_STORE_RND);
   // rounded store: add half lsb of high word, wrap at top is accepted
   wire logic [WORD_W-1:0] store_word = (op_code == DACC_OP_STORE_RND) ?
      WORD_W'(acc_sel[PROD_W-1:WORD_W] + {{(WORD_W-1){1'b0}}, acc_sel[WORD_W-1]}) :
      acc_sel[PROD_W-1:WORD_W]; // RULE12

   // register decode
   wire logic hit_first = reg_addr == REG_FIRST_LOW || reg_addr == REG_FIRST_HIGH ||
                          reg_addr == REG_FIRST_GUARD;
   wire logic hit_second = reg_addr == REG_SECOND_LOW || reg_addr == REG_SECOND_HIGH ||
                           reg_addr == REG_SECOND_GUARD;
   wire logic wr_acc_idx = hit_second;
   wire logic [ADDR_W-1:0] field_idx = hit_second ? ADDR_W'(reg_addr - REG_SECOND_LOW) :
                                       reg_addr;
   wire logic [ACC_W-1:0] acc_wr_tgt = acc_reg[wr_acc_idx];
   // byte write touches only low byte; upper byte keeps stored value
   wire logic [WORD_W-1:0] old_word =
      (field_idx == REG_FIRST_LOW) ? acc_wr_tgt[WORD_W-1:0] :
      (field_idx == REG_FIRST_HIGH) ? acc_wr_tgt[PROD_W-1:WORD_W] :
      {{GUARD_W{acc_wr_tgt[ACC_W-1]}}, acc_wr_tgt[ACC_W-1:PROD_W]};
   wire logic [WORD_W-1:0] merged_word = reg_byte ?
      {old_word[WORD_W-1:GUARD_W], reg_wdata[GUARD_W-1:0]} : reg_wdata;
   // guard write keeps only the byte; the read view is rebuilt by extension
   wire logic [ACC_W-1:0] acc_wr_val =
      (field_idx == REG_FIRST_LOW) ? {acc_wr_tgt[ACC_W-1:WORD_W], merged_word} :
      (field_idx == REG_FIRST_HIGH) ?
         {acc_wr_tgt[ACC_W-1:PROD_W], merged_word, acc_wr_tgt[WORD_W-1:0]} :
         {merged_word[GUARD_W-1:0], acc_wr_tgt[PROD_W-1:0]}; // RULE15
   wire logic reg_wr_acc = reg_wr && (hit_first || hit_second); // RULE15
   wire logic reg_wr_ctl = reg_wr && reg_addr == REG_CORE_CTL;

   // read mux; guard word is sign extended so byte or word reads agree
   wire logic [ACC_W-1:0] acc_rd_src = acc_reg[hit_second];
   wire logic [WORD_W-1:0] rd_word =
      (hit_first || hit_second) ?
         ((field_idx == REG_FIRST_LOW) ? acc_rd_src[WORD_W-1:0] :
          (field_idx == REG_FIRST_HIGH) ? acc_rd_src[PROD_W-1:WORD_W] :
          {{GUARD_W{acc_rd_src[ACC_W-1]}}, acc_rd_src[ACC_W-1:PROD_W]}) : // RULE16
      (reg_addr == REG_CORE_CTL) ? ctl_reg : 16'h0000;

   // next-state for both accumulators; instruction beats register write
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         acc_next[i] = acc_reg[i];
         if (op_valid && (is_arith || is_load) && op_acc_sel == 1'(i)) begin
            acc_next[i] = is_load ? load_val : dsp_res; // RULE10 RULE11
         end else if (reg_wr_acc && wr_acc_idx == 1'(i)) begin
            acc_next[i] = acc_wr_val; // RULE15
         end
      end
   end

   // control word next value; byte write changes low byte only
   assign ctl_next = reg_wr_ctl ?
      (reg_byte ? {ctl_reg[CTL_W-1:GUARD_W], reg_wdata[GUARD_W-1:0]} : reg_wdata) : ctl_reg;

   // state registers
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         acc_reg[0] <= ACC_RESET;
         acc_reg[1] <= ACC_RESET;
         ctl_reg <= CTL_RESET;
      end else begin
         acc_reg[0] <= acc_next[0];
         acc_reg[1] <= acc_next[1];
         ctl_reg <= ctl_next;
      end
   end

   // read data and store word are registered one cycle after strobe
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdata_reg <= 16'h0000;
         store_reg <= 16'h0000;
         store_vld_reg <= 1'b0;
      end else begin
         if (reg_rd) begin
            rdata_reg <= rd_word;
         end
         if (is_store) begin
            store_reg <= store_word; // RULE12
         end
         store_vld_reg <= is_store;
      end
   end

   assign reg_rdata = rdata_reg;
   assign store_data = store_reg;
   assign store_valid = store_vld_reg;
   assign core_control_reg = ctl_reg;

   // assertions; the MPY checks rebuild products from sign-extended operands so that
   // a fault inside the multiplier cannot hide behind its own output; the MAC and MSC checks reuse product

   // load puts the word in the high register, zero low, sign in guard
   a_load_alignment: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
      is_load |=> acc_reg[$past(op_acc_sel)] ==
         {{8{$past(op_x[15])}}, $past(op_x), 16'h0000})
      else $error("load alignment wrong");

   // plain store hands out the high register untouched
   a_store_high: assert property (@(posedge mclk) disable iff (!resetn) // RULE12
      (is_store && op_code == DACC_OP_STORE) |=> store_valid &&
         store_data == $past(acc_sel[31:16]))
      else $error("store did not take high word");

   // rounded store adds bit 15 of the low register to the high word
   a_store_round: assert property (@(posedge mclk) disable iff (!resetn) // RULE12
      (is_store && op_code == DACC_OP_STORE_RND) |=> store_valid &&
         store_data == $past(acc_sel[31:16]) + $past(acc_sel[15]))
      else $error("rounded store wrong");

   // the store strobe only ever follows a store instruction
   a_store_pulse: assert property (@(posedge mclk) disable iff (!resetn) // RULE12
      store_valid |-> $past(is_store))
      else $error("store strobe without store");

   // the stored word holds between stores
   a_store_hold: assert property (@(posedge mclk) disable iff (!resetn) // RULE12
      ($past(resetn) && !$past(is_store)) |-> $stable(store_data))
      else $error("store word changed without store");

   // normal mode regenerates the guard from bit 31 after every arithmetic operation
   a_normal_guard: assert property (@(posedge mclk) disable iff (!resetn) // RULE13
      (is_arith && !super_sat) |=>
         acc_reg[$past(op_acc_sel)][39:32] == {8{acc_reg[$past(op_acc_sel)][31]}})
      else $error("guard not sign extension in normal mode");

   // normal mode keeps the 32-bit sum of old low 32 bits and product
   a_normal_mac: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
      (is_arith && !super_sat && op_code == DACC_OP_MAC) |=>
         acc_reg[$past(op_acc_sel)][31:0] == $past(acc_sel[31:0]) + $past(product))
      else $error("normal mode sum wrong");

   // super saturation accumulates over all 40 bits
   a_super_wide: assert property (@(posedge mclk) disable iff (!resetn) // RULE14
      (is_arith && super_sat && op_code == DACC_OP_MAC) |=>
         acc_reg[$past(op_acc_sel)] == $past(sum_mac))
      else $error("super saturation result not 40 bits");

   // subtraction reaches into the guard byte as well
   a_super_sub: assert property (@(posedge mclk) disable iff (!resetn) // RULE14
      (is_arith && super_sat && op_code == DACC_OP_MSC) |=>
         acc_reg[$past(op_acc_sel)] ==
            $past(acc_sel) - {{8{$past(product[31])}}, $past(product)})
      else $error("super saturation subtract wrong");

   // a fresh fractional product stays on the 1.31 point, guard is only sign
   a_super_frac: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
      (op_valid && op_code == DACC_OP_MPY && super_sat && !int_mode) |=>
         acc_reg[$past(op_acc_sel)][39:32] == {8{acc_reg[$past(op_acc_sel)][31]}})
      else $error("fractional product moved off 1.31 point");

   // adding accumulators is plain binary in super saturation
   a_add_both: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      (is_arith && super_sat && op_code == DACC_OP_ADD) |=>
         acc_reg[$past(op_acc_sel)] == $past(acc_reg[0]) + $past(acc_reg[1]))
      else $error("accumulator add wrong");

   // and keeps the low 32 bits of that sum in normal mode
   a_add_normal: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      (is_arith && !super_sat && op_code == DACC_OP_ADD) |=>
         acc_reg[$past(op_acc_sel)][31:0] ==
            $past(acc_reg[0][31:0]) + $past(acc_reg[1][31:0]))
      else $error("normal mode add wrong");

   // integer multiply is the full signed product, unshifted
   a_int_product: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
      (op_valid && op_code == DACC_OP_MPY && int_mode) |=>
         acc_reg[$past(op_acc_sel)][31:0] ==
            {{16{$past(op_x[15])}}, $past(op_x)} * {{16{$past(op_y[15])}}, $past(op_y)})
      else $error("integer product wrong");

   // fractional multiply is the same product moved up one place
   a_frac_shift: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      (op_valid && op_code == DACC_OP_MPY && !int_mode) |=>
         acc_reg[$past(op_acc_sel)][31:0] ==
            ({{16{$past(op_x[15])}}, $past(op_x)} * {{16{$past(op_y[15])}}, $past(op_y)}) << 1)
      else $error("fractional product not shifted");

   // a control write steers the very next instruction
   a_mode_next: assert property (@(posedge mclk) disable iff (!resetn) // RULE18
      (reg_wr && !reg_byte && reg_addr == REG_CORE_CTL) |=>
         int_mode == $past(reg_wdata[CTL_IF_BIT]) &&
         super_sat == $past(reg_wdata[CTL_SSAT_BIT]))
      else $error("mode bits not taken from control write");

   // without a control write the mode cannot drift
   a_mode_steady: assert property (@(posedge mclk) disable iff (!resetn) // RULE18
      ($past(resetn) && !$past(reg_wr_ctl)) |-> $stable(core_control_reg))
      else $error("control word changed without write");

   // word write to control replaces the whole word
   a_ctl_word: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
      (reg_wr && !reg_byte && reg_addr == REG_CORE_CTL) |=>
         core_control_reg == $past(reg_wdata))
      else $error("control word write lost");

   // byte write to control keeps the upper byte
   a_ctl_byte: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
      (reg_wr && reg_byte && reg_addr == REG_CORE_CTL) |=>
         core_control_reg == {$past(core_control_reg[15:8]), $past(reg_wdata[7:0])})
      else $error("control byte write wrong");

   // word write to a low register lands when no instruction claims it
   a_reg_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_wr && !reg_byte && reg_addr == REG_SECOND_LOW && !(op_valid && op_acc_sel)) |=>
         acc_reg[1][15:0] == $past(reg_wdata))
      else $error("accumulator register write lost");

   // word write to a high register
   a_high_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_wr && !reg_byte && reg_addr == REG_FIRST_HIGH &&
         !((is_arith || is_load) && !op_acc_sel)) |=>
         acc_reg[0][31:16] == $past(reg_wdata))
      else $error("high register write lost");

   // guard write keeps the low byte of the data, byte or word alike
   a_guard_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_wr && reg_addr == REG_FIRST_GUARD && !((is_arith || is_load) && !op_acc_sel)) |=>
         acc_reg[0][39:32] == $past(reg_wdata[7:0]))
      else $error("guard register write lost");

   // an instruction on the same accumulator wins over a register write
   a_instr_wins: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_wr && reg_addr == REG_SECOND_HIGH && is_load && op_acc_sel) |=>
         acc_reg[1][31:16] == $past(op_x))
      else $error("register write beat instruction");

   // guard reads come back sign extended to a word
   a_guard_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
      (reg_rd && reg_addr == REG_FIRST_GUARD) |=>
         reg_rdata[15:8] == {8{reg_rdata[7]}} && reg_rdata[7:0] == $past(acc_reg[0][39:32]))
      else $error("guard read not sign extended");

   // same for the second accumulator's guard
   a_second_guard: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
      (reg_rd && reg_addr == REG_SECOND_GUARD) |=>
         reg_rdata == {{8{$past(acc_reg[1][39])}}, $past(acc_reg[1][39:32])})
      else $error("second guard read wrong");

   // high register read
   a_high_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_rd && reg_addr == REG_FIRST_HIGH) |=>
         reg_rdata == $past(acc_reg[0][31:16]))
      else $error("high register read wrong");

   // low register read
   a_low_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_rd && reg_addr == REG_SECOND_LOW) |=>
         reg_rdata == $past(acc_reg[1][15:0]))
      else $error("low register read wrong");

   // the unused index reads as zero
   a_unused_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      (reg_rd && reg_addr == 3'h7) |=> reg_rdata == 16'h0000)
      else $error("unused index read not zero");

   // read data holds until the next read
   a_read_hold: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      ($past(resetn) && !$past(reg_rd)) |-> $stable(reg_rdata))
      else $error("read data changed without read");
endmodule // dacc_core

// file: tb/dacc_xy_path.sv
// model of the core x and y data paths that feed operand words
`timescale 1ns/1ns
module dacc_xy_path (
   input wire logic mclk, // core clock
   input wire logic drive, // an instruction owns the buses
   input wire logic [15:0] x_word, // x word to present
   input wire logic [15:0] y_word, // y word to present
   output logic [15:0] op_x, // x bus
   output logic [15:0] op_y // y bus
);
   logic [15:0] junk_reg = 16'h5a3c;
   // idle buses toggle so a stale operand never passes for a fresh one
   always @(negedge mclk) junk_reg <= ~junk_reg;
   // operands only appear while an instruction executes
   assign op_x = drive ? x_word : junk_reg;
   assign op_y = drive ? y_word : ~junk_reg;
endmodule // dacc_xy_path

// file: tb/dsp_accumulator_number_formats_test.sv
// self-checking bench for the dsp accumulator datapath
`timescale 1ns/1ns
module dsp_accumulator_number_formats_test;
   import dacc_pkg::*;
   logic mclk = 0, resetn = 0, op_valid = 0, op_acc_sel = 0, reg_wr = 0, reg_rd = 0, reg_byte = 0;
   dacc_op_t op_code = DACC_OP_NONE;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] x_w = 16'h0, y_w = 16'h0, reg_wdata = 16'h0, op_x, op_y, store_data;
   logic [15:0] reg_rdata, core_control_reg, ctl = 16'h0;
   logic store_valid, rd_d = 0, cw_d = 0;
   logic [39:0] acc [2] = '{40'h0, 40'h0};
   logic [15:0] q_st[$], q_rd[$], q_ct[$];
   logic [31:0] r, q;
   int errors = 0, total_checks = 0;
   integer seed = 32'hc7fd;
   always #20 mclk = ~mclk;
   dacc_xy_path xy (.mclk(mclk), .drive(op_valid), .x_word(x_w), .y_word(y_w), .op_x(op_x),
      .op_y(op_y));
   dacc_core uut (.mclk(mclk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
      .op_acc_sel(op_acc_sel), .op_x(op_x), .op_y(op_y), .store_data(store_data),
      .store_valid(store_valid), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_byte(reg_byte),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .core_control_reg(core_control_reg));
   task automatic check_store(input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected store_data expected %h seen %h", e, s);
      end
   endtask
   task automatic check_read(input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected reg_rdata expected %h seen %h", e, s);
      end
   endtask
   task automatic check_ctl(input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected core_control_reg expected %h seen %h", e, s);
      end
   endtask
   // normal mode keeps 32 bits and only sign-extends into the guard
   function automatic logic [39:0] fix(input logic [39:0] v);
      return ctl[CTL_SSAT_BIT] ? v : {{8{v[31]}}, v[31:0]};
   endfunction
   function automatic logic [15:0] rdv(input logic [2:0] a);
      logic [39:0] v;
      v = acc[a >= 3'h3];
      case (a)
         REG_FIRST_LOW, REG_SECOND_LOW: return v[15:0];
         REG_FIRST_HIGH, REG_SECOND_HIGH: return v[31:16];
         REG_FIRST_GUARD, REG_SECOND_GUARD: return {{8{v[39]}}, v[39:32]};
         REG_CORE_CTL: return ctl;
         default: return 16'h0000;
      endcase
   endfunction
   task automatic wreg(input logic [2:0] a, input logic b, input logic [15:0] d);
      logic [15:0] m;
      m = rdv(a);
      m = b ? {m[15:8], d[7:0]} : d;
      case (a)
         REG_FIRST_LOW, REG_SECOND_LOW: acc[a >= 3'h3][15:0] = m;
         REG_FIRST_HIGH, REG_SECOND_HIGH: acc[a >= 3'h3][31:16] = m;
         REG_FIRST_GUARD, REG_SECOND_GUARD: acc[a >= 3'h3][39:32] = m[7:0];
         REG_CORE_CTL: ctl = m;
         default: ;
      endcase
      if (a == REG_CORE_CTL) q_ct.push_back(m);
   endtask
   // one cycle of stimulus; the model notes what the design must answer
   task automatic cyc(input logic v, input dacc_op_t c, input logic s, input logic [15:0] x,
      input logic [15:0] y, input logic w, input logic rd, input logic b, input logic [2:0] a,
      input logic [15:0] d);
      logic signed [31:0] p;
      logic [39:0] pe;
      logic own;
      op_valid = v;
      op_code = c;
      op_acc_sel = s;
      x_w = x;
      y_w = y;
      reg_wr = w;
      reg_rd = rd;
      reg_byte = b;
      reg_addr = a;
      reg_wdata = d;
      // a read sees the state from before this cycle's instruction and write
      if (rd) q_rd.push_back(rdv(a));
      // an instruction writing the same accumulator drops the register write
      own = v && (c inside {DACC_OP_MPY, DACC_OP_MAC, DACC_OP_MSC, DACC_OP_LOAD, DACC_OP_ADD})
         && a < 3'h6 && s == (a >= 3'h3);
      p = $signed(x) * $signed(y);
      if (!ctl[CTL_IF_BIT]) p = p <<< 1;
      pe = {{8{p[31]}}, p};
      if (v) case (c)
         DACC_OP_MPY: acc[s] = fix(pe);
         DACC_OP_MAC: acc[s] = fix(acc[s] + pe);
         DACC_OP_MSC: acc[s] = fix(acc[s] - pe);
         DACC_OP_LOAD: acc[s] = {{8{x[15]}}, x, 16'h0000};
         DACC_OP_STORE: q_st.push_back(acc[s][31:16]);
         DACC_OP_STORE_RND: q_st.push_back(acc[s][31:16] + acc[s][15]);
         DACC_OP_ADD: acc[s] = fix(acc[0] + acc[1]);
         default: ;
      endcase
      if (w && !own) wreg(a, b, d);
      @(negedge mclk);
   endtask
   task automatic op(input dacc_op_t c, input logic s, input logic [15:0] x, input logic [15:0] y);
      cyc(1'b1, c, s, x, y, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0000);
   endtask
   task automatic rg(input logic w, input logic b, input logic [2:0] a, input logic [15:0] d);
      cyc(1'b0, DACC_OP_NONE, 1'b0, 16'h0000, 16'h0000, w, !w, b, a, d);
   endtask
   task automatic dump;
      for (int a = 0; a < 8; a++) rg(1'b0, 1'b0, a[2:0], 16'h0000);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // read results appear the cycle after the taking edge
   always @(posedge mclk) begin
      rd_d <= reg_rd;
      cw_d <= reg_wr && reg_addr == REG_CORE_CTL;
   end
   // monitor: each result is compared with the oldest note
   always @(negedge mclk) begin
      if (store_valid === 1'b1) check_store(q_st.size() ? q_st.pop_front() : 'x, store_data);
      if (rd_d) check_read(q_rd.size() ? q_rd.pop_front() : 'x, reg_rdata);
      if (cw_d) check_ctl(q_ct.size() ? q_ct.pop_front() : 'x, core_control_reg);
   end
   initial begin
      repeat (20) @(negedge mclk);
      resetn = 1;
      dump();
      // mode change takes hold on the very next instruction
      rg(1'b1, 1'b0, REG_CORE_CTL, 16'h0001);
      op(DACC_OP_MPY, 1'b0, 16'h0003, 16'hfffe);
      op(DACC_OP_STORE, 1'b0, 16'h0000, 16'h0000);
      rg(1'b1, 1'b0, REG_CORE_CTL, 16'h0000);
      op(DACC_OP_MPY, 1'b1, 16'h4000, 16'h4000);
      op(DACC_OP_STORE_RND, 1'b1, 16'h0000, 16'h0000);
      // push past bit 31 in normal then super saturation
      for (int m = 0; m < 2; m++) begin
         rg(1'b1, 1'b0, REG_CORE_CTL, m ? 16'h0011 : 16'h0001);
         op(DACC_OP_MPY, 1'b0, 16'h7fff, 16'h7fff);
         repeat (3) op(DACC_OP_MAC, 1'b0, 16'h7fff, 16'h7fff);
         op(DACC_OP_MSC, 1'b0, 16'h0002, 16'h0001);
         dump();
      end
      rg(1'b1, 1'b1, REG_SECOND_HIGH, 16'h1234);
      rg(1'b1, 1'b1, REG_SECOND_GUARD, 16'hff80);
      rg(1'b1, 1'b0, 3'h7, 16'hffff);
      // load and register write on the same accumulator in one cycle
      cyc(1'b1, DACC_OP_LOAD, 1'b1, 16'h8001, 16'h0000, 1'b1, 1'b0, 1'b0, REG_SECOND_HIGH,
         16'h1234);
      dump();
      // random soak over every operation, mode and register
      repeat (300) begin
         r = $random(seed);
         q = $random(seed);
         cyc(r[0], dacc_op_t'(r[3:1]), r[4], r[31:16], q[15:0], r[5], r[10],
            r[6] && r[5], r[9:7], q[31:16]);
      end
      dump();
      cyc(1'b0, DACC_OP_NONE, 1'b0, 16'h0, 16'h0, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0);
      for (int i = 0; i < 10 && (q_st.size() || q_rd.size() || q_ct.size()); i++) @(negedge mclk);
      if (q_st.size() || q_rd.size() || q_ct.size()) errors++;
      final_report();
   end
endmodule // dsp_accumulator_number_formats_test
